// >>> verilog/twe_eeprom.sv
/*
 * Target side of a two-wire serial EEPROM with a 512 x 8 array, page buffer,
 * self-timed programming and random / sequential reads.
 * Assumes SCL and SDA arrive asynchronously and are oversampled by CLK_I,
 * which must run well above the bus bit rate; SDA wire level is resolved
 * outside from SDA_OE_O.
 */
// Functional notes
// - Array of 512 byte locations, each individually addressable over the bus.
// - Page writes of up to 16 bytes, partial pages accepted.
// - Programming runs on internal timing after stop, ending within 5 ms.
// - Random reads and sequential reads of successive locations in one transfer.
// - Respond only when select bits equal the two strapped chip-select levels.
// - Undriven chip-select or write-protect inputs are treated as low.
// - Data line is only pulled low; high is expressed by releasing it.
// - Commands and data bits are captured at rising serial clock edges.
// - Output data changes only after a falling serial clock edge.
// - Write-protect input, when asserted, blocks programming of the whole array.
// - Write-protect low writes normally; high inhibits all array writes.
`timescale 1ns/1ps
`default_nettype none
module twe_eeprom #(
  parameter int unsigned WR_CYCLES = twe_pkg::WR_CYC
) (
  input  wire logic CLK_I,
  input  wire logic RST_I,
  input  wire logic SCL_I,
  input  wire logic SDA_I,
  input  wire logic CHIP_SELECT_STRAP_LOW_I,
  input  wire logic CHIP_SELECT_STRAP_HIGH_I,
  input  wire logic WRITE_PROTECT_I,
  output var  logic SDA_O,
  output var  logic SDA_OE_O,
  output var  logic BUSY_O
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and bus event detection

  twe_pkg::twe_link_t  link_s;
  twe_pkg::twe_link_t  link_p;
  twe_pkg::twe_strap_t strap_s;
  twe_pkg::twe_link_t  link_raw;
  twe_pkg::twe_strap_t strap_raw;

  assign link_raw  = '{scl: SCL_I, sda: SDA_I};
  // Pad pull-downs make a floating strap read as low
  assign strap_raw = '{wp: WRITE_PROTECT_I, cs_hi: CHIP_SELECT_STRAP_HIGH_I,
                       cs_lo: CHIP_SELECT_STRAP_LOW_I};

  twe_sync #(
    .W ($bits(twe_pkg::twe_link_t))
  ) u_link_sync (
    .clk_i (CLK_I),
    .rst_i (RST_I),
    .d_i   (link_raw),
    .q_o   (link_s)
  );

  twe_sync #(
    .W ($bits(twe_pkg::twe_strap_t))
  ) u_strap_sync (
    .clk_i (CLK_I),
    .rst_i (RST_I),
    .d_i   (strap_raw),
    .q_o   (strap_s)
  );

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      link_p <= '0;
    end else begin
      link_p <= link_s;
    end
  end

  wire scl_rise = link_s.scl & ~link_p.scl;
  wire scl_fall = ~link_s.scl & link_p.scl;
  // Start and stop are data edges while the clock stays high
  wire bus_start = link_s.scl & link_p.scl & link_p.sda & ~link_s.sda;
  wire bus_stop  = link_s.scl & link_p.scl & ~link_p.sda & link_s.sda;

  ////////////////////////////////////////////////////////////////////////////
  // Protocol state

  twe_pkg::twe_state_t                    state_q;
  logic [3:0]                             cnt_q;
  logic [7:0]                             rx_q;
  logic [7:0]                             tx_q;
  logic                                   ack_q;
  logic                                   rw_q;
  logic                                   hi_bit_q;
  logic [twe_pkg::ADDR_W-1:0]             addr_q;
  logic [7:0]                             mem_q   [twe_pkg::MEM_DEPTH];
  logic [7:0]                             page_q  [twe_pkg::PAGE_BYTES];
  logic [twe_pkg::PAGE_BYTES-1:0]         valid_q;
  logic [twe_pkg::ADDR_W-twe_pkg::PAGE_W-1:0] page_base_q;
  logic                                   prog_busy;
  logic                                   prog_done;

  wire [7:0] rx_next   = {rx_q[6:0], link_s.sda};
  wire       byte_done = scl_fall && (cnt_q == twe_pkg::BITS_PER_BYTE);
  wire       is_rx     = (state_q == twe_pkg::ST_DEV) || (state_q == twe_pkg::ST_WADR) ||
                         (state_q == twe_pkg::ST_WDAT);

  // Device select byte: type code, two straps, block bit, direction
  wire dev_match = (rx_q[7:4] == twe_pkg::DEV_TYPE) &&
                   (rx_q[3] == strap_s.cs_hi) &&
                   (rx_q[2] == strap_s.cs_lo);
  // A busy array answers no select byte until programming ends
  wire dev_ok    = dev_match && !prog_busy;
  wire data_ok   = !strap_s.wp;

  wire take_byte = byte_done && (state_q == twe_pkg::ST_WDAT) && data_ok;
  wire prog_go   = bus_stop && (|valid_q) && !prog_busy && !strap_s.wp;

  wire [7:0] rd_data = mem_q[addr_q];

  twe_wr_timer #(
    .CYCLES (WR_CYCLES)
  ) u_wr_timer (
    .clk_i   (CLK_I),
    .rst_i   (RST_I),
    .start_i (prog_go),
    .busy_o  (prog_busy),
    .done_o  (prog_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Byte-level sequencer

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      state_q  <= twe_pkg::ST_IDLE;
      cnt_q    <= twe_pkg::CNT_RST;
      rx_q     <= twe_pkg::BYTE_RST;
      tx_q     <= twe_pkg::BYTE_RST;
      ack_q    <= 1'b0;
      rw_q     <= 1'b0;
      hi_bit_q <= 1'b0;
      addr_q   <= twe_pkg::ADDR_RST;
    end else if (bus_start) begin
      state_q <= twe_pkg::ST_DEV;
      cnt_q   <= twe_pkg::CNT_RST;
      ack_q   <= 1'b0;
    end else if (bus_stop) begin
      state_q <= twe_pkg::ST_IDLE;
      ack_q   <= 1'b0;
    end else begin
      case (state_q)
        twe_pkg::ST_DEV, twe_pkg::ST_WADR, twe_pkg::ST_WDAT: begin
          if (scl_rise) begin
            rx_q  <= rx_next;
            cnt_q <= cnt_q + 4'h1;
          end else if (byte_done) begin
            cnt_q <= twe_pkg::CNT_RST;
            case (state_q)
              twe_pkg::ST_DEV: begin
                state_q  <= twe_pkg::ST_DEV_ACK;
                ack_q    <= dev_ok;
                rw_q     <= rx_q[0];
                hi_bit_q <= rx_q[1];
                tx_q     <= rd_data;
              end
              twe_pkg::ST_WADR: begin
                state_q <= twe_pkg::ST_WADR_ACK;
                ack_q   <= 1'b1;
                addr_q  <= {hi_bit_q, rx_q};
              end
              default: begin
                state_q <= twe_pkg::ST_WDAT_ACK;
                ack_q   <= data_ok;
                if (data_ok) begin
                  addr_q[twe_pkg::PAGE_W-1:0] <= addr_q[twe_pkg::PAGE_W-1:0] + 4'h1;
                end
              end
            endcase
          end
        end
        twe_pkg::ST_DEV_ACK, twe_pkg::ST_WADR_ACK, twe_pkg::ST_WDAT_ACK: begin
          if (scl_fall) begin
            if (!ack_q) begin
              state_q <= twe_pkg::ST_IDLE;
            end else if (state_q == twe_pkg::ST_DEV_ACK) begin
              state_q <= rw_q ? twe_pkg::ST_RD : twe_pkg::ST_WADR;
            end else begin
              state_q <= twe_pkg::ST_WDAT;
            end
            ack_q <= 1'b0;
          end
        end
        twe_pkg::ST_RD: begin
          if (scl_rise) begin
            cnt_q <= cnt_q + 4'h1;
          end else if (byte_done) begin
            state_q <= twe_pkg::ST_RD_ACK;
            cnt_q   <= twe_pkg::CNT_RST;
            addr_q  <= addr_q + 9'h001;
          end else if (scl_fall) begin
            tx_q <= {tx_q[6:0], 1'b1};
          end
        end
        twe_pkg::ST_RD_ACK: begin
          if (scl_rise) begin
            ack_q <= ~link_s.sda;
          end else if (scl_fall) begin
            // Controller acknowledge continues the sequential read
            state_q <= ack_q ? twe_pkg::ST_RD : twe_pkg::ST_IDLE;
            tx_q    <= rd_data;
            ack_q   <= 1'b0;
          end
        end
        default: begin
          state_q <= twe_pkg::ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Page buffer and array

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      valid_q     <= '0;
      page_base_q <= '0;
    end else if (prog_done) begin
      valid_q <= '0;
    end else if (bus_start && !prog_busy) begin
      // An interrupted write never reaches the array
      valid_q <= '0;
    end else if (take_byte) begin
      valid_q[addr_q[twe_pkg::PAGE_W-1:0]] <= 1'b1;
      page_base_q <= addr_q[twe_pkg::ADDR_W-1:twe_pkg::PAGE_W];
    end
  end

  always_ff @(posedge CLK_I) begin
    if (take_byte) begin
      page_q[addr_q[twe_pkg::PAGE_W-1:0]] <= rx_q;
    end
  end

  // Array has no reset: its contents are meant to survive it
  always_ff @(posedge CLK_I) begin
    if (prog_done) begin
      for (int i = 0; i < twe_pkg::PAGE_BYTES; i++) begin
        if (valid_q[i]) begin
          mem_q[{page_base_q, twe_pkg::PAGE_W'(i)}] <= page_q[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Open-drain data drive

  wire ack_phase = (state_q == twe_pkg::ST_DEV_ACK) || (state_q == twe_pkg::ST_WADR_ACK) ||
                   (state_q == twe_pkg::ST_WDAT_ACK);
  wire pull_low  = (ack_phase && ack_q) || ((state_q == twe_pkg::ST_RD) && !tx_q[7]);

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      SDA_O    <= 1'b0;
      SDA_OE_O <= 1'b0;
      BUSY_O   <= 1'b0;
    end else begin
      SDA_O    <= 1'b0;
      SDA_OE_O <= pull_low && !bus_start && !bus_stop;
      BUSY_O   <= prog_busy;
    end
  end

endmodule
`default_nettype wire

// >>> pkg/twe_pkg.sv
/*
 * Shared constants, state codes and pin bundles of the two-wire EEPROM target.
 * Assumes a single 125 MHz system clock.
 */
package twe_pkg;

  localparam int ADDR_W     = 9;
  localparam int MEM_DEPTH  = 512;
  localparam int PAGE_BYTES = 16;
  localparam int PAGE_W     = 4;

  localparam logic [3:0] DEV_TYPE      = 4'hA;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] CNT_RST       = 4'h0;
  localparam logic [8:0] ADDR_RST      = 9'h000;
  localparam logic [7:0] BYTE_RST      = 8'h00;

  localparam int CLK_PERIOD_NS = 8;
  localparam int T_WR_MS       = 5;
  localparam int T_WR_NS       = T_WR_MS * 1_000_000;
  // Longest time: round down
  localparam int WR_CYC        = T_WR_NS / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'b0000,
    ST_DEV      = 4'b0001,
    ST_DEV_ACK  = 4'b0010,
    ST_WADR     = 4'b0011,
    ST_WADR_ACK = 4'b0100,
    ST_WDAT     = 4'b0101,
    ST_WDAT_ACK = 4'b0110,
    ST_RD       = 4'b0111,
    ST_RD_ACK   = 4'b1000
  } twe_state_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } twe_link_t;

  typedef struct packed {
    logic wp;
    logic cs_hi;
    logic cs_lo;
  } twe_strap_t;

endpackage

// >>> verilog/twe_sync.sv
/*
 * Two-flop synchroniser for a bundle of asynchronous levels.
 * Assumes inputs are static or slow against CLK.
 */
`timescale 1ns/1ps
`default_nettype none
module twe_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output var  logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      q_o    <= '0;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule
`default_nettype wire

// >>> verilog/twe_wr_timer.sv
/*
 * Self-timed programming interval: busy for CYCLES clocks after a start pulse.
 * Assumes start is ignored while busy.
 */
`timescale 1ns/1ps
`default_nettype none
module twe_wr_timer #(
  parameter int unsigned CYCLES = 2
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic start_i,
  output var  logic busy_o,
  output var  logic done_o
);
  logic [31:0] cnt_q;
  wire         last = (cnt_q == 32'(CYCLES - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q  <= 32'h0000_0000;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= busy_o & last;
      if (start_i && !busy_o) begin
        busy_o <= 1'b1;
        cnt_q  <= 32'h0000_0000;
      end else if (busy_o) begin
        cnt_q  <= cnt_q + 32'h0000_0001;
        busy_o <= !last;
      end
    end
  end
endmodule
`default_nettype wire

// >>> dv/twe_eeprom_asserts.sv
/* Port checker of twe_eeprom.
   Assumes the bind below and the bench WR_CYCLES value. */
`timescale 1ns/1ps
`default_nettype none
module twe_eeprom_asserts #(
  parameter int unsigned WR_CYCLES = 2
) (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic SCL_I,
  input wire logic SDA_I,
  input wire logic CHIP_SELECT_STRAP_LOW_I,
  input wire logic CHIP_SELECT_STRAP_HIGH_I,
  input wire logic WRITE_PROTECT_I,
  input wire logic SDA_O,
  input wire logic SDA_OE_O,
  input wire logic BUSY_O
);
  localparam int BMAX = WR_CYCLES + 4;
  logic [31:0] cnt_q;
  always_ff @(posedge CLK_I) begin
    cnt_q <= (RST_I || !BUSY_O) ? '0 : cnt_q + 1;
  end
  ////////////////////////////////////////////////////////////////
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  // A bit driven on a fall must not move while the clock is high
  sequence s_hold;
    ##1 $stable(SDA_OE_O)[*8];
  endsequence
  a_low_only: assert property (SDA_OE_O |-> !SDA_O)
    else $error("data line driven high");
  a_oe_after_fall: assert property ($changed(SDA_OE_O) |-> !SCL_I && !$past(SCL_I, 2))
    else $error("data changed outside clock low");
  a_oe_hold_high: assert property ($rose(SCL_I) |-> s_hold)
    else $error("data moved in clock high");
  a_busy_max: assert property (cnt_q <= BMAX)
    else $error("programming too long");
  a_busy_min: assert property ($fell(BUSY_O) |-> cnt_q >= WR_CYCLES)
    else $error("programming too short");
  a_busy_at_stop: assert property ($rose(BUSY_O) |-> $past(SCL_I) && $past(SCL_I, 6))
    else $error("programming not after stop");
  a_wp_no_prog: assert property ($rose(BUSY_O) |-> !$past(WRITE_PROTECT_I, 8))
    else $error("programming under protect");
  a_busy_silent: assert property (BUSY_O && $past(BUSY_O) |-> !SDA_OE_O)
    else $error("answered while busy");
endmodule
bind twe_eeprom twe_eeprom_asserts #(.WR_CYCLES(WR_CYCLES)) u_chk (.CLK_I(CLK_I), .RST_I(RST_I),
  .SCL_I(SCL_I), .SDA_I(SDA_I), .CHIP_SELECT_STRAP_LOW_I(CHIP_SELECT_STRAP_LOW_I),
  .CHIP_SELECT_STRAP_HIGH_I(CHIP_SELECT_STRAP_HIGH_I), .WRITE_PROTECT_I(WRITE_PROTECT_I),
  .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O), .BUSY_O(BUSY_O));
`default_nettype wire

// >>> dv/twe_ctl.sv
/* Behavioural two-wire bus controller.
   Assumes the bench resolves the data wire; HP is a clock phase in CLK cycles. */
`timescale 1ns/1ps
`default_nettype none
module twe_ctl #(
  parameter int HP = 25
) (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output var  logic scl_o,
  output var  logic sda_low_o
);
  initial begin
    scl_o = 1'h1;
    sda_low_o = 1'h0;
  end
  // Every change lands just after a clock edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic start();
    tick(5);
    sda_low_o = 1'h0;
    tick(HP);
    scl_o = 1'h1;
    tick(HP);
    sda_low_o = 1'h1;
    tick(HP);
    scl_o = 1'h0;
  endtask
  task automatic stop();
    tick(5);
    sda_low_o = 1'h1;
    tick(HP);
    scl_o = 1'h1;
    tick(HP);
    sda_low_o = 1'h0;
    tick(HP);
  endtask
  // Data settles 5 cycles into the low phase, so it never meets the fall
  task automatic bit_x(input logic b, output logic r);
    tick(5);
    sda_low_o = !b;
    tick(HP);
    scl_o = 1'h1;
    tick(HP);
    r = sda_i;
    scl_o = 1'h0;
  endtask
  task automatic send(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(v[i], r);
    bit_x(1'h1, r);
    ack = !r;
  endtask
  task automatic recv(input logic more, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'h1, v[i]);
    bit_x(!more, r);
  endtask
endmodule
`default_nettype wire

// >>> dv/test_two_wire_eeprom_target_front.sv
/* Self-checking bench of twe_eeprom.
   Assumes twe_ctl as the bus controller and a pulled-up data wire. */
`timescale 1ns/1ps
`default_nettype none
module test_two_wire_eeprom_target_front;
  localparam int WRC = 1500;
  // Row: strap high, strap low, sent bit3, sent bit2, expected ack
  localparam logic [4:0] ROWS [5] = '{5'h01, 5'h15, 5'h08, 5'h1C, 5'h02};
  logic       clk, rst, cs_hi, cs_lo, wp, ack, scl, sda_low, oe, sdo, busy, sda;
  logic [7:0] v;
  int         miscompares, total_checks, cycles;
  assign sda = (oe ? sdo : 1'h1) & !sda_low;
  twe_ctl ctl (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
  twe_eeprom #(.WR_CYCLES(WRC)) dut (.CLK_I(clk), .RST_I(rst), .SCL_I(scl), .SDA_I(sda),
    .CHIP_SELECT_STRAP_LOW_I(cs_lo), .CHIP_SELECT_STRAP_HIGH_I(cs_hi), .WRITE_PROTECT_I(wp),
    .SDA_O(sdo), .SDA_OE_O(oe), .BUSY_O(busy));
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      miscompares++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      miscompares++;
    end
  endtask
  task automatic end_of_test();
    if (miscompares == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  function automatic logic [7:0] sel(input logic [1:0] cs, input logic blk, input logic rd);
    return {twe_pkg::DEV_TYPE, cs, blk, rd};
  endfunction
  // Page from 0x10E, 17 bytes: the last one lands on the first again
  function automatic logic [7:0] expv(input int k);
    return (k == 14) ? 8'h40 : 8'h30 + 8'((k + 2) % 16);
  endfunction
  task automatic addr_rd(input logic [7:0] a, input int n);
    ctl.start();
    ctl.send(sel(2'h2, 1'h1, 1'h0), ack);
    ctl.send(a, ack);
    ctl.start();
    ctl.send(sel(2'h2, 1'h1, 1'h1), ack);
    chk("read select ack", 8'h01, {7'h0, ack});
    for (int k = 0; k < n; k++) begin
      ctl.recv(k < n - 1, v);
      chk("read data", expv(int'(a) + k), v);
    end
    ctl.stop();
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'h1;
    {cs_hi, cs_lo, wp} = 3'h0;
    repeat (4) @(posedge clk);
    #1 rst = 1'h0;
    ctl.tick(8);
    foreach (ROWS[i]) begin
      {cs_hi, cs_lo} = ROWS[i][4:3];
      ctl.tick(4);
      ctl.start();
      ctl.send(sel(ROWS[i][2:1], 1'h0, 1'h0), ack);
      ctl.stop();
      chk("select ack", {7'h0, ROWS[i][0]}, {7'h0, ack});
    end
    {cs_hi, cs_lo} = 2'h2;
    ctl.start();
    ctl.send(sel(2'h2, 1'h1, 1'h0), ack);
    ctl.send(8'h0E, ack);
    for (int i = 0; i < 17; i++) begin
      ctl.send(8'h30 + 8'(i), ack);
      chk("page byte ack", 8'h01, {7'h0, ack});
    end
    ctl.stop();
    chk("busy after stop", 8'h01, {7'h0, busy});
    ctl.start();
    ctl.send(sel(2'h2, 1'h1, 1'h0), ack);
    ctl.stop();
    chk("poll while busy", 8'h00, {7'h0, ack});
    for (int i = 0; i < WRC && busy; i++) ctl.tick(1);
    chk("busy ends", 8'h00, {7'h0, busy});
    addr_rd(8'h00, 16);
    wp = 1'h1;
    ctl.start();
    ctl.send(sel(2'h2, 1'h1, 1'h0), ack);
    ctl.send(8'h05, ack);
    chk("protect addr ack", 8'h01, {7'h0, ack});
    ctl.send(8'hEE, ack);
    chk("protect data nack", 8'h00, {7'h0, ack});
    ctl.stop();
    chk("protect no busy", 8'h00, {7'h0, busy});
    wp = 1'h0;
    addr_rd(8'h05, 1);
    // Current-address read continues from the location after the last one read
    ctl.start();
    ctl.send(sel(2'h2, 1'h1, 1'h1), ack);
    chk("current select ack", 8'h01, {7'h0, ack});
    ctl.recv(1'h0, v);
    chk("current read data", expv(6), v);
    ctl.stop();
    end_of_test();
  end
endmodule
`default_nettype wire
